// ---- cwd_regs.svh ----
`ifndef CWD_REGS_SVH
`define CWD_REGS_SVH

// Register offsets, as host-visible 16-bit register addresses
`define CWD_OFS_RUN_CONTROL    16'hf0a0
`define CWD_OFS_EXTRA_OPTIONS  16'hf0a2
`define CWD_OFS_PERIOD_SECONDS 16'hf0a4
`define CWD_OFS_STARTUP_SECS   16'hf0a6
`define CWD_OFS_KEYED_MODE_ON  16'hf0aa
`define CWD_OFS_CLEAR_KEY      16'hf0ac
`define CWD_OFS_KICK           16'hf0ae
`define CWD_OFS_REBOOT_ON      16'hf0b4
`define CWD_OFS_PIN_ACTION_ON  16'hf0be
`define CWD_OFS_PIN_LEVEL      16'hf0c0
`define CWD_OFS_PIN_DIR        16'hf0c2
`define CWD_OFS_PIN_HOLD       16'hf0c4
`define CWD_OFS_AOUT_A_ON      16'hf0c8
`define CWD_OFS_AOUT_A_VOLTS   16'hf0ca
`define CWD_OFS_AOUT_B_ON      16'hf0d2
`define CWD_OFS_AOUT_B_VOLTS   16'hf0d4

// Field positions
`define CWD_BIT_ENABLE         0
`define CWD_BIT_ADV_FACTORY    0
`define CWD_BIT_ADV_SAVED      1

// Reset values
`define CWD_RST_WORD           32'h0000_0000
`define CWD_RST_PERIOD         32'h0000_003c
`define CWD_RST_STARTUP        32'h0000_0000

// Timing: device clock rate and the watchdog tick in seconds
`define CWD_CLK_HZ             50000000
`define CWD_TICK_S             1

`endif

// ---- cwd_pkg.sv ----
package cwd_pkg;

    // Watchdog sequencing states
    typedef enum logic [1:0] {
        CWD_STOP = 2'b00,
        CWD_RUN  = 2'b01,
        CWD_FIRE = 2'b10
    } cwd_state_t;

    // Complete state of the watchdog block
    typedef struct packed {
        cwd_state_t  state;
        logic        run;
        logic [31:0] extra_options;
        logic [31:0] period_s;
        logic [31:0] startup_s;
        logic        keyed;
        logic [31:0] key;
        logic        reboot_on;
        logic        pin_on;
        logic [31:0] pin_level;
        logic [31:0] pin_dir;
        logic [31:0] pin_hold;
        logic        aout_a_on;
        logic [31:0] aout_a_volts;
        logic        aout_b_on;
        logic [31:0] aout_b_volts;
        logic        startup_phase;
        logic [31:0] div_cnt;
        logic [31:0] sec_cnt;
        logic [31:0] rdata;
        logic        rvalid;
        logic        pin_apply;
        logic        aout_a_apply;
        logic        aout_b_apply;
        logic        load_factory;
        logic        load_saved;
        logic        dev_reset;
    } cwd_regs_t;

endpackage : cwd_pkg

// ---- cwd_comm_loss_watchdog.sv ----
`include "cwd_regs.svh"

// Behaviour
// - Writing 1 to the run control starts the watchdog; writing 0 stops it.
// - Timeout in seconds is 32 bits; outside keyed mode, received host traffic clears the timer.
// - Timer reaching the timeout uncleared performs every enabled action.
// - Outside keyed mode, each command response sent restarts the timeout.
// - Reboot action enabled resets the device each timeout, repeating without traffic.
// - Pin action enabled applies stored level, direction and hold masks on timeout.
// - First analog action enabled drives the stored float voltage on timeout.
// - Second analog action enabled drives its stored float voltage on timeout.
// - Timeouts as short as one second are accepted.
// - Keyed mode on stops command responses from restarting the timeout.
// - In keyed mode only a kick write equal to the key clears.
// - A 32-bit readable and writable key holds the value kicks must match.
// - Outside keyed mode any kick write clears, whatever the value.
// - A kick write clears at once, not when its response goes out.
// - Streamed data never restarts the timeout; only command-response traffic does.
// - After boot a startup timeout applies until the first clear or timeout.
module cwd_comm_loss_watchdog #(
    parameter logic [31:0] SEC_CYCLES = 32'(`CWD_CLK_HZ * `CWD_TICK_S)
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // Register access port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Host traffic events
    input wire logic cmd_rx_in,
    input wire logic cmd_resp_sent_in,
    // Digital pin action
    output logic pin_apply_out,
    output logic [31:0] pin_level_field_out,
    output logic [31:0] pin_dir_field_out,
    output logic [31:0] pin_hold_field_out,
    // Analog output actions
    output logic aout_a_apply_out,
    output logic [31:0] analog_out_a_volts_out,
    output logic aout_b_apply_out,
    output logic [31:0] analog_out_b_volts_out,
    // Setup reload and reset actions
    output logic load_factory_io_setup_out,
    output logic load_saved_io_setup_out,
    output logic device_reset_out,
    // Status
    output logic wd_running_out,
    output logic wd_startup_phase_out,
    output logic [31:0] wd_elapsed_s_out
);

    cwd_pkg::cwd_regs_t st_ff;
    cwd_pkg::cwd_regs_t nxt_st;

    logic wr_kick;
    logic kick;
    logic tick;
    logic [31:0] limit_s;
    logic [31:0] sec_next;

    // Kick write, checked against the key only in keyed mode
    assign wr_kick = reg_wr_in && (reg_addr_in == `CWD_OFS_KICK)
                     && (!st_ff.keyed || (reg_wdata_in == st_ff.key));

    // Clear sources; stream traffic has no input here at all
    assign kick = wr_kick
                  || (!st_ff.keyed && (cmd_rx_in || cmd_resp_sent_in));

    // One-second tick from the clock divider
    assign tick = (st_ff.div_cnt == SEC_CYCLES - 32'h1);

    // Active limit: startup delay first, zero treated as one second
    always_comb begin
        limit_s = st_ff.period_s;
        if (st_ff.startup_phase && (st_ff.startup_s != 32'h0)) begin
            limit_s = st_ff.startup_s;
        end
        if (limit_s == 32'h0) begin
            limit_s = 32'h1;
        end
    end

    assign sec_next = 32'(st_ff.sec_cnt + 32'h1);

    // Next-state logic for registers, timer and action pulses
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pin_apply = 1'b0;
        nxt_st.aout_a_apply = 1'b0;
        nxt_st.aout_b_apply = 1'b0;
        nxt_st.load_factory = 1'b0;
        nxt_st.load_saved = 1'b0;
        nxt_st.dev_reset = 1'b0;
        nxt_st.rvalid = reg_rd_in;
        nxt_st.rdata = 32'h0;

        // Register reads; unmapped and write-only read as zero
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `CWD_OFS_RUN_CONTROL: nxt_st.rdata = {31'h0, st_ff.run};
                `CWD_OFS_EXTRA_OPTIONS: nxt_st.rdata = st_ff.extra_options;
                `CWD_OFS_PERIOD_SECONDS: nxt_st.rdata = st_ff.period_s;
                `CWD_OFS_STARTUP_SECS: nxt_st.rdata = st_ff.startup_s;
                `CWD_OFS_KEYED_MODE_ON: nxt_st.rdata = {31'h0, st_ff.keyed};
                `CWD_OFS_CLEAR_KEY: nxt_st.rdata = st_ff.key;
                `CWD_OFS_REBOOT_ON: nxt_st.rdata = {31'h0, st_ff.reboot_on};
                `CWD_OFS_PIN_ACTION_ON: nxt_st.rdata = {31'h0, st_ff.pin_on};
                `CWD_OFS_PIN_LEVEL: nxt_st.rdata = st_ff.pin_level;
                `CWD_OFS_PIN_DIR: nxt_st.rdata = st_ff.pin_dir;
                `CWD_OFS_PIN_HOLD: nxt_st.rdata = st_ff.pin_hold;
                `CWD_OFS_AOUT_A_ON: nxt_st.rdata = {31'h0, st_ff.aout_a_on};
                `CWD_OFS_AOUT_A_VOLTS: nxt_st.rdata = st_ff.aout_a_volts;
                `CWD_OFS_AOUT_B_ON: nxt_st.rdata = {31'h0, st_ff.aout_b_on};
                `CWD_OFS_AOUT_B_VOLTS: nxt_st.rdata = st_ff.aout_b_volts;
                default: nxt_st.rdata = 32'h0;
            endcase
        end

        // Configuration writes; host keeps the watchdog stopped meanwhile
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                `CWD_OFS_RUN_CONTROL: nxt_st.run = reg_wdata_in[`CWD_BIT_ENABLE];
                `CWD_OFS_EXTRA_OPTIONS: nxt_st.extra_options = reg_wdata_in;
                `CWD_OFS_PERIOD_SECONDS: nxt_st.period_s = reg_wdata_in;
                `CWD_OFS_STARTUP_SECS: nxt_st.startup_s = reg_wdata_in;
                `CWD_OFS_KEYED_MODE_ON: nxt_st.keyed = reg_wdata_in[`CWD_BIT_ENABLE];
                `CWD_OFS_CLEAR_KEY: nxt_st.key = reg_wdata_in;
                `CWD_OFS_REBOOT_ON: nxt_st.reboot_on = reg_wdata_in[`CWD_BIT_ENABLE];
                `CWD_OFS_PIN_ACTION_ON: nxt_st.pin_on = reg_wdata_in[`CWD_BIT_ENABLE];
                `CWD_OFS_PIN_LEVEL: nxt_st.pin_level = reg_wdata_in;
                `CWD_OFS_PIN_DIR: nxt_st.pin_dir = reg_wdata_in;
                `CWD_OFS_PIN_HOLD: nxt_st.pin_hold = reg_wdata_in;
                `CWD_OFS_AOUT_A_ON: nxt_st.aout_a_on = reg_wdata_in[`CWD_BIT_ENABLE];
                `CWD_OFS_AOUT_A_VOLTS: nxt_st.aout_a_volts = reg_wdata_in;
                `CWD_OFS_AOUT_B_ON: nxt_st.aout_b_on = reg_wdata_in[`CWD_BIT_ENABLE];
                `CWD_OFS_AOUT_B_VOLTS: nxt_st.aout_b_volts = reg_wdata_in;
                default: ;
            endcase
        end

        // Watchdog sequencer
        unique case (st_ff.state)
            cwd_pkg::CWD_STOP: begin
                nxt_st.div_cnt = 32'h0;
                nxt_st.sec_cnt = 32'h0;
                if (st_ff.run) begin
                    nxt_st.state = cwd_pkg::CWD_RUN;
                end
            end
            cwd_pkg::CWD_RUN: begin
                nxt_st.div_cnt = tick ? 32'h0 : 32'(st_ff.div_cnt + 32'h1);
                if (!st_ff.run) begin
                    nxt_st.state = cwd_pkg::CWD_STOP;
                end else if (kick) begin
                    // A clear in the same cycle as expiry wins
                    nxt_st.div_cnt = 32'h0;
                    nxt_st.sec_cnt = 32'h0;
                    nxt_st.startup_phase = 1'b0;
                end else if (tick) begin
                    if (sec_next >= limit_s) begin
                        // Expiry: drive every enabled output and setup action
                        nxt_st.sec_cnt = 32'h0;
                        nxt_st.startup_phase = 1'b0;
                        nxt_st.pin_apply = st_ff.pin_on;
                        nxt_st.aout_a_apply = st_ff.aout_a_on;
                        nxt_st.aout_b_apply = st_ff.aout_b_on;
                        nxt_st.load_factory = st_ff.extra_options[`CWD_BIT_ADV_FACTORY];
                        nxt_st.load_saved = st_ff.extra_options[`CWD_BIT_ADV_SAVED];
                        nxt_st.state = cwd_pkg::CWD_FIRE;
                    end else begin
                        nxt_st.sec_cnt = sec_next;
                    end
                end
            end
            cwd_pkg::CWD_FIRE: begin
                // Reset follows the other actions, then timing restarts
                nxt_st.dev_reset = st_ff.reboot_on;
                nxt_st.div_cnt = 32'h0;
                nxt_st.sec_cnt = 32'h0;
                nxt_st.state = st_ff.run ? cwd_pkg::CWD_RUN : cwd_pkg::CWD_STOP;
            end
            default: begin
                nxt_st.state = cwd_pkg::CWD_STOP;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff <= '{
                state: cwd_pkg::CWD_STOP,
                run: 1'b0,
                extra_options: `CWD_RST_WORD,
                period_s: `CWD_RST_PERIOD,
                startup_s: `CWD_RST_STARTUP,
                keyed: 1'b0,
                key: `CWD_RST_WORD,
                reboot_on: 1'b0,
                pin_on: 1'b0,
                pin_level: `CWD_RST_WORD,
                pin_dir: `CWD_RST_WORD,
                pin_hold: `CWD_RST_WORD,
                aout_a_on: 1'b0,
                aout_a_volts: `CWD_RST_WORD,
                aout_b_on: 1'b0,
                aout_b_volts: `CWD_RST_WORD,
                startup_phase: 1'b1,
                div_cnt: 32'h0,
                sec_cnt: 32'h0,
                rdata: 32'h0,
                rvalid: 1'b0,
                pin_apply: 1'b0,
                aout_a_apply: 1'b0,
                aout_b_apply: 1'b0,
                load_factory: 1'b0,
                load_saved: 1'b0,
                dev_reset: 1'b0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_out = st_ff.rdata;
    assign reg_rvalid_out = st_ff.rvalid;
    assign pin_apply_out = st_ff.pin_apply;
    assign pin_level_field_out = st_ff.pin_level;
    assign pin_dir_field_out = st_ff.pin_dir;
    assign pin_hold_field_out = st_ff.pin_hold;
    assign aout_a_apply_out = st_ff.aout_a_apply;
    assign analog_out_a_volts_out = st_ff.aout_a_volts;
    assign aout_b_apply_out = st_ff.aout_b_apply;
    assign analog_out_b_volts_out = st_ff.aout_b_volts;
    assign load_factory_io_setup_out = st_ff.load_factory;
    assign load_saved_io_setup_out = st_ff.load_saved;
    assign device_reset_out = st_ff.dev_reset;
    assign wd_running_out = (st_ff.state != cwd_pkg::CWD_STOP);
    assign wd_startup_phase_out = st_ff.startup_phase;
    assign wd_elapsed_s_out = st_ff.sec_cnt;

endmodule : cwd_comm_loss_watchdog

// ---- cwd_chk.sv ----
// Port-level checks on the watchdog top module
module cwd_chk (
    // Clock, reset and register port
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_rvalid_out,
    // Action and status outputs
    input wire logic pin_apply_out,
    input wire logic aout_a_apply_out,
    input wire logic device_reset_out,
    input wire logic wd_running_out,
    input wire logic [31:0] pin_level_field_out,
    input wire logic [31:0] wd_elapsed_s_out
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    // Read answers come exactly one cycle later
    AST_READ_ANSWER: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
    AST_NO_SPURIOUS_VALID: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray read valid");
    // Run control start and stop
    AST_RUN_START: assert property (reg_wr_in && reg_addr_in == 16'hf0a0 && reg_wdata_in[0]
        |-> ##2 wd_running_out) else $error("watchdog did not start");
    AST_RUN_STOP: assert property (reg_wr_in && reg_addr_in == 16'hf0a0 && !reg_wdata_in[0]
        |-> ##2 !wd_running_out) else $error("watchdog did not stop");
    // Stored pin level reaches the pin level output
    AST_PIN_LEVEL: assert property (reg_wr_in && reg_addr_in == 16'hf0c0
        |-> ##2 pin_level_field_out == $past(reg_wdata_in, 2)) else $error("pin level not stored");
    // Pin pulse lasts a single cycle; the reset pulse is single and never coincides with the pin or first analog pulse
    AST_PIN_PULSE: assert property (pin_apply_out |=> !pin_apply_out) else $error("pin pulse too long");
    AST_RESET_AFTER: assert property (device_reset_out |-> !pin_apply_out && !aout_a_apply_out
        && !$past(device_reset_out)) else $error("reset not after actions");
    // Elapsed seconds step by one or clear
    AST_ELAPSED_STEP: assert property (wd_elapsed_s_out != $past(wd_elapsed_s_out)
        |-> wd_elapsed_s_out == $past(wd_elapsed_s_out) + 32'h1 || wd_elapsed_s_out == 32'h0)
        else $error("elapsed seconds jumped");
    AST_STOP_IDLE: assert property (!wd_running_out |=> wd_elapsed_s_out == 32'h0)
        else $error("counting while stopped");

    // Main scenarios reached
    COV_FIRE: cover property (pin_apply_out ##1 device_reset_out);
    COV_START: cover property (!wd_running_out ##1 wd_running_out);
    COV_READ: cover property (reg_rd_in ##1 reg_rvalid_out);
endmodule : cwd_chk

// ---- cwd_host_mdl.sv ----
// Host computer: sends a command packet on request, its response follows later
module cwd_host_mdl #(
    parameter int RESP_DLY = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Request from the bench and traffic events
    input wire logic send_in,
    output logic cmd_rx_out = 1'b0,
    output logic resp_sent_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    // Only command-response traffic is produced, never stream data
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_rx_out <= 1'b0;
            resp_sent_out <= 1'b0;
            cnt <= 0;
        end else begin
            cmd_rx_out <= send_in;
            resp_sent_out <= (cnt == 1);
            cnt <= send_in ? RESP_DLY : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule : cwd_host_mdl

// ---- tb_top.sv ----
// Bench for the communication-loss watchdog
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} cwd_row_t;
    logic ref_clk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0, host_send = 0;
    logic cmd_rx_in, cmd_resp_sent_in, reg_rvalid_out, pin_apply_out, aout_a_apply_out, aout_b_apply_out;
    logic load_factory_io_setup_out, load_saved_io_setup_out, device_reset_out, wd_running_out, wd_startup_phase_out;
    logic [15:0] reg_addr_in = 0;
    logic [31:0] reg_wdata_in = 0, reg_rdata_out, pin_level_field_out, pin_dir_field_out, pin_hold_field_out;
    logic [31:0] analog_out_a_volts_out, analog_out_b_volts_out, wd_elapsed_s_out;
    int err_count = 0, n_tests = 0, fires = 0, cyc = 0;
    cwd_row_t rows[16] = '{'{16'hf0a2, 32'h3, 32'h3}, '{16'hf0a4, 32'h2, 32'h2}, '{16'hf0aa, 32'hfffffffe, 32'h0},
        '{16'hf0ac, 32'h5a5ac3c3, 32'h5a5ac3c3}, '{16'hf0ae, 32'h1234, 32'h0}, '{16'hf0b4, 32'h1, 32'h1},
        '{16'hf0be, 32'h3, 32'h1}, '{16'hf0c0, 32'ha5a50f0f, 32'ha5a50f0f}, '{16'hf0c2, 32'hff, 32'hff},
        '{16'hf0c4, 32'h101, 32'h101}, '{16'hf0c8, 32'h1, 32'h1}, '{16'hf0ca, 32'h40a00000, 32'h40a00000},
        '{16'hf0d2, 32'h1, 32'h1}, '{16'hf0d4, 32'hc0400000, 32'hc0400000}, '{16'hf0a8, 32'h7, 32'h0},
        '{16'hf0a6, 32'h3, 32'h3}};

    cwd_comm_loss_watchdog #(.SEC_CYCLES(32'h4)) dut (.ref_clk_in, .nrst_in, .reg_wr_in, .reg_rd_in,
        .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .cmd_rx_in, .cmd_resp_sent_in,
        .pin_apply_out, .pin_level_field_out, .pin_dir_field_out, .pin_hold_field_out, .aout_a_apply_out,
        .analog_out_a_volts_out, .aout_b_apply_out, .analog_out_b_volts_out, .load_factory_io_setup_out,
        .load_saved_io_setup_out, .device_reset_out, .wd_running_out, .wd_startup_phase_out, .wd_elapsed_s_out);
    cwd_host_mdl #(.RESP_DLY(2)) host (.clk_in(ref_clk_in), .nrst_in, .send_in(host_send),
        .cmd_rx_out(cmd_rx_in), .resp_sent_out(cmd_resp_sent_in));

    // Clock, fire counter and hang guard
    always #10 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        if (pin_apply_out === 1'b1) fires++;
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            $display("MISMATCH t=%0t run did not finish", $time);
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk({31'h0, reg_rvalid_out}, 32'h1, "read valid");
        chk(reg_rdata_out, e, "read data");
    endtask : rd

    // Waits for an action pulse, then checks its delay, the actions and the later reset
    task automatic wait_fire(input int n_exp);
        int n = 0;
        while (n < 40 && pin_apply_out !== 1'b1) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        chk(n, n_exp, "fire delay");
        chk({aout_a_apply_out, aout_b_apply_out, load_factory_io_setup_out, load_saved_io_setup_out,
            device_reset_out}, 32'h1e, "fire set");
        chk(pin_level_field_out, 32'ha5a50f0f, "pin level");
        chk(pin_dir_field_out, 32'hff, "pin dir");
        chk(pin_hold_field_out, 32'h101, "pin hold");
        chk(analog_out_a_volts_out, 32'h40a00000, "volts a");
        chk(analog_out_b_volts_out, 32'hc0400000, "volts b");
        @(posedge ref_clk_in);
        #1;
        chk({31'h0, device_reset_out}, 32'h1, "device reset");
    endtask : wait_fire

    // Host traffic or kick writes every five cycles
    task automatic soak(input int n, input int kind, input logic [31:0] v);
        fires = 0;
        repeat (n) begin
            if (kind == 0) begin
                @(posedge ref_clk_in);
                host_send <= 1'b1;
                @(posedge ref_clk_in);
                host_send <= 1'b0;
            end else wr(16'hf0ae, v);
            repeat (3) @(posedge ref_clk_in);
        end
    endtask : soak

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        #1;
        chk({30'h0, wd_startup_phase_out, wd_running_out}, 32'h2, "reset status");
        rd(16'hf0a4, 32'h3c);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        $display("register table done");
        wr(16'hf0a4, 32'h1);
        wr(16'hf0a0, 32'h1);
        // Startup delay 3 s of 4 cycles each, after one cycle to leave STOP
        wait_fire(13);
        chk({31'h0, wd_startup_phase_out}, 32'h0, "startup ended");
        // Then the 1 s period: 4 cycles of counting after the fire cycle
        wait_fire(4);
        $display("timeout actions done");
        wr(16'hf0a0, 32'h0);
        wr(16'hf0a4, 32'h2);
        wr(16'hf0a0, 32'h1);
        soak(12, 0, 32'h0);
        chk(fires, 32'h0, "traffic clears");
        soak(12, 1, 32'hdead0001);
        chk(fires, 32'h0, "any kick clears");
        wr(16'hf0a0, 32'h0);
        wr(16'hf0aa, 32'h1);
        wr(16'hf0a0, 32'h1);
        soak(12, 0, 32'h0);
        chk({31'h0, fires > 0}, 32'h1, "keyed ignores traffic");
        soak(12, 1, 32'h5a5ac3c2);
        chk({31'h0, fires > 0}, 32'h1, "wrong key ignored");
        // Restart so that no expiry left from the last soak lands in the next count
        wr(16'hf0a0, 32'h0);
        wr(16'hf0a0, 32'h1);
        soak(12, 1, 32'h5a5ac3c3);
        chk(fires, 32'h0, "right key clears");
        $display("clearing done");
        // Reset in mid-run returns every register to its reset value
        @(posedge ref_clk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        #1;
        chk({30'h0, wd_startup_phase_out, wd_running_out}, 32'h2, "second reset status");
        chk(pin_level_field_out, 32'h0, "pin level after reset");
        rd(16'hf0a4, 32'h3c);
        rd(16'hf0aa, 32'h0);
        rd(16'hf0ac, 32'h0);
        $display("second reset done");
        final_report();
    end
endmodule : tb_top

bind cwd_comm_loss_watchdog cwd_chk u_chk (.ref_clk_in, .nrst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rvalid_out, .pin_apply_out, .aout_a_apply_out, .device_reset_out, .wd_running_out,
    .pin_level_field_out, .wd_elapsed_s_out);
